/* bench/adcsq_host.sv */
// Purpose: Serial host model that clocks one result word out
// Assumes: Each strobe stands for one serial clock falling edge
// Notes:   Data bit is sampled before each strobe, as a host latches it
`timescale 1ns/10ps
module adcsq_host (
  input  wire logic mclk,
  input  wire logic sdo_bit,
  output logic      cs_n,
  output logic      sck_fall
);
  // Idle with select high, so no frame starts by accident
  initial begin
    cs_n     = 1'b1;
    sck_fall = 1'b0;
  end

  // Select, take 32 bits MSB first, then release select
  task automatic read_word(output logic [31:0] w);
    @(posedge mclk) cs_n <= 1'b0;
    repeat (2) @(posedge mclk);
    for (int i = 31; i >= 0; i--) begin
      #1 w[i] = sdo_bit;
      @(posedge mclk) sck_fall <= 1'b1;
      @(posedge mclk) sck_fall <= 1'b0;
      @(posedge mclk);
    end
    cs_n <= 1'b1;
  endtask
endmodule // adcsq_host

/* bench/test_adcsq_top.sv */
// Purpose: Self-checking bench for the conversion sequencer
// Assumes: Short reset count; conversion clock toggled every mclk rising edge
// Notes:   Only one conversion fits in the run, timed on the outside clock
`timescale 1ns/10ps
module test_adcsq_top
  import adcsq_pkg::*;
;
  logic          mclk, reset_n, supply_ok, conv_clock_pin, cs_n, sck_fall;
  logic          cfg_load, ext_run, pin_q, clk_en;
  adcsq_cfg_s    cfg_in;
  adcsq_result_s mod_result;
  logic          por_active, ext_clk_sel, osc_enable, conv_busy, cal_offset_en;
  logic [1:0]    reject_mode;
  logic          rate_2x, temp_sel, sdo_bit, sdo_oe, word_done;
  logic [31:0]   w;
  logic [1:0]    codes [3] = '{REJ_50, REJ_60, REJ_CMB};
  int            miscompares = 0, n_compared = 0, n_edges = 0, n_done = 0, cyc = 0, n;
  int            n_oe = 0;

  adcsq_top #(.POR_CYCLES(20)) DUT (
    .mclk(mclk), .reset_n(reset_n), .clk_en(clk_en), .supply_ok(supply_ok),
    .conv_clock_pin(conv_clock_pin), .cs_n(cs_n), .sck_fall(sck_fall),
    .cfg_load(cfg_load), .cfg_in(cfg_in), .mod_result(mod_result),
    .por_active(por_active), .ext_clk_sel(ext_clk_sel), .osc_enable(osc_enable),
    .conv_busy(conv_busy), .cal_offset_en(cal_offset_en), .reject_mode(reject_mode),
    .rate_2x(rate_2x), .temp_sel(temp_sel), .sdo_bit(sdo_bit), .sdo_oe(sdo_oe),
    .word_done(word_done)
  );
  adcsq_host HOST (.mclk(mclk), .sdo_bit(sdo_bit), .cs_n(cs_n), .sck_fall(sck_fall));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Outside clock far above the detection floor; edge and pulse counters
  always @(posedge mclk) begin
    if (ext_run) conv_clock_pin <= ~conv_clock_pin;
    pin_q <= conv_clock_pin;
    if (conv_clock_pin && !pin_q && conv_busy && !por_active) n_edges <= n_edges + 1;
    if (word_done === 1'b1) n_done <= n_done + 1;
    if (sdo_oe === 1'b1) n_oe <= n_oe + 1;
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      miscompares++;
      final_report();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One configuration write; result is settled on return
  task automatic wr(input logic en, input logic im, input logic [1:0] code, input logic dr);
    @(posedge mclk);
    cfg_in <= '{enable: en, temp_input_select: im, reject_sel_a: code[1],
                reject_sel_b: code[0], double_rate_select: dr};
    cfg_load <= 1'b1;
    @(posedge mclk) cfg_load <= 1'b0;
    #1;
  endtask

  // Bounded wait for reset to end, counting cycles
  task automatic wait_por();
    for (n = 0; n < 40 && por_active !== 1'b0; n++) @(posedge mclk);
    #1;
  endtask

  task automatic final_report();
    $display("compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    reset_n = 1'b0;
    supply_ok = 1'b1;
    conv_clock_pin = 1'b0;
    ext_run = 1'b1;
    cfg_load = 1'b0;
    clk_en = 1'b1;
    cfg_in = '0;
    mod_result = '{sign: 1'b0, value: 24'hC3A596, sub_lsb: 5'h15, over: 1'b0, under: 1'b0};
    repeat (8) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk) #1;
    chk(por_active, 1);
    chk(reject_mode, REJ_CMB);
    wait_por();
    chk(n >= 18 && n <= 22, 1);
    chk(conv_busy, 1);
    $display("test reset done");
    // Every legal code, then refused writes leave the mode alone
    foreach (codes[i]) begin
      wr(1'b1, 1'b0, codes[i], 1'b0);
      chk(reject_mode, codes[i]);
    end
    wr(1'b1, 1'b0, REJ_RSVD, 1'b1);
    chk({reject_mode, rate_2x}, {REJ_CMB, 1'b0});
    wr(1'b0, 1'b0, REJ_60, 1'b1);
    chk({reject_mode, rate_2x}, {REJ_CMB, 1'b0});
    wr(1'b1, 1'b1, REJ_50, 1'b1);
    chk({temp_sel, rate_2x, cal_offset_en}, 3'b101);
    wr(1'b1, 1'b0, REJ_CMB, 1'b1);
    chk({rate_2x, cal_offset_en}, 2'b10);
    chk({ext_clk_sel, osc_enable}, 2'b10);
    $display("test config done");
    for (n = 0; n < 45000 && conv_busy !== 1'b0; n++) @(posedge mclk);
    #1;
    chk(n_edges >= 20552 && n_edges <= 20560, 1);
    chk(sdo_bit, 0);
    repeat (50) @(posedge mclk);
    chk(conv_busy, 0);
    // Low clock enable drops a write and holds sleep
    @(posedge mclk) clk_en <= 1'b0;
    wr(1'b1, 1'b0, REJ_60, 1'b0);
    chk({reject_mode, rate_2x, conv_busy}, {REJ_CMB, 1'b1, 1'b0});
    chk(sdo_oe, 0);
    @(posedge mclk) clk_en <= 1'b1;
    HOST.read_word(w);
    chk(w, {3'b000, 24'hC3A596, 5'h15});
    @(posedge mclk) #1;
    chk(n_done, 1);
    chk(n_oe, 98);
    chk({sdo_bit, conv_busy}, 2'b11);
    $display("test conversion done");
    ext_run <= 1'b0;
    repeat (EXT_LOSS_CYC - 20) @(posedge mclk);
    #1;
    chk(ext_clk_sel, 1);
    repeat (40) @(posedge mclk);
    #1;
    chk({ext_clk_sel, osc_enable}, 2'b01);
    $display("test fallback done");
    wr(1'b1, 1'b0, REJ_60, 1'b1);
    @(posedge mclk) supply_ok <= 1'b0;
    repeat (3) @(posedge mclk);
    #1;
    chk({por_active, reject_mode, rate_2x}, {1'b1, REJ_CMB, 1'b0});
    @(posedge mclk) supply_ok <= 1'b1;
    wait_por();
    chk(conv_busy, 1);
    $display("test supply drop done");
    final_report();
  end
endmodule // test_adcsq_top

/* hw/adcsq_top.sv */
// Purpose: Convert, sleep and output sequencing of a delta-sigma converter
// Assumes: All inputs synchronous to mclk; serial clock edges given as strobes
// Notes:   Result value comes from the modulator as a plain input
`timescale 1ns/10ps
module adcsq_top
  import adcsq_pkg::*;
#(
  parameter int POR_CYCLES = POR_CYC
) (
  input  wire logic          mclk,
  input  wire logic          reset_n,
  input  wire logic          clk_en,
  input  wire logic          supply_ok,
  input  wire logic          conv_clock_pin,
  input  wire logic          cs_n,
  input  wire logic          sck_fall,
  input  wire logic          cfg_load,
  input  wire adcsq_cfg_s    cfg_in,
  input  wire adcsq_result_s mod_result,
  output logic               por_active,
  output logic               ext_clk_sel,
  output logic               osc_enable,
  output logic               conv_busy,
  output logic               cal_offset_en,
  output logic [1:0]         reject_mode,
  output logic               rate_2x,
  output logic               temp_sel,
  output logic               sdo_bit,
  output logic               sdo_oe,
  output logic               word_done
);

  adcsq_state_e state;
  adcsq_state_e next_state;
  logic [31:0]  por_cnt;
  logic [31:0]  loss_cnt;
  logic         pin_q;
  logic         ext_edge;
  logic [31:0]  conv_cnt;
  logic [31:0]  conv_term;
  logic [5:0]   bit_cnt;
  logic [31:0]  shift_word;
  logic [31:0]  word;
  logic         zero_sign;
  logic         conv_done;

  // Supply monitor drives the internal reset hold and pulse
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      por_cnt    <= '0;
      por_active <= 1'b1;
    end else if (clk_en) begin
      if (!supply_ok) begin
        por_cnt    <= '0;
        por_active <= 1'b1;
      end else if (por_cnt < POR_CYCLES - 1) begin
        por_cnt    <= por_cnt + 32'd1;
      end else begin
        por_active <= 1'b0;
      end
    end
  end

  // Edge detect on the conversion clock pin
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pin_q <= 1'b0;
    end else if (clk_en) begin
      pin_q <= conv_clock_pin;
    end
  end
  assign ext_edge = conv_clock_pin & ~pin_q;

  // Presence detect; gaps longer than a 10 kHz period mean no clock
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      loss_cnt    <= '0;
      ext_clk_sel <= 1'b0;
    end else if (clk_en) begin
      if (por_active) begin
        loss_cnt    <= '0;
        ext_clk_sel <= 1'b0;
      end else if (ext_edge) begin
        loss_cnt    <= '0;
        ext_clk_sel <= 1'b1;
      end else if (loss_cnt >= EXT_LOSS_CYC) begin
        ext_clk_sel <= 1'b0;
      end else begin
        loss_cnt    <= loss_cnt + 32'd1;
      end
    end
  end
  assign osc_enable = ~ext_clk_sel;

  // Configuration register; cleared by power-on reset
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      reject_mode <= REJ_CMB;
      rate_2x     <= 1'b0;
      temp_sel    <= 1'b0;
    end else if (clk_en) begin
      if (por_active) begin
        reject_mode <= REJ_CMB;
        rate_2x     <= 1'b0;
        temp_sel    <= 1'b0;
      end else if (cfg_load && cfg_in.enable &&
                   {cfg_in.reject_sel_a, cfg_in.reject_sel_b} != REJ_RSVD) begin
        reject_mode <= {cfg_in.reject_sel_a, cfg_in.reject_sel_b};
        temp_sel    <= cfg_in.temp_input_select;
        // Temperature input always runs at normal speed
        rate_2x     <= cfg_in.double_rate_select & ~cfg_in.temp_input_select;
      end
    end
  end

  // Offset pass only in 1x; it is part of the conversion time
  assign cal_offset_en = ~rate_2x;

  // Terminal count picked per source, speed and rejection
  always_comb begin
    conv_term = 32'(CCMB_1X_CYC);
    if (ext_clk_sel) begin
      conv_term = rate_2x ? 32'(EXT_CONV_2X) : 32'(EXT_CONV_1X);
    end else begin
      unique case (reject_mode)
        REJ_60:  conv_term = rate_2x ? 32'(C60_2X_CYC) : 32'(C60_1X_CYC);
        REJ_50:  conv_term = rate_2x ? 32'(C50_2X_CYC) : 32'(C50_1X_CYC);
        default: conv_term = rate_2x ? 32'(CCMB_2X_CYC) : 32'(CCMB_1X_CYC);
      endcase
    end
  end

  // Counter advances on the selected conversion clock
  assign conv_done = (state == ADCSQ_CONV) && (conv_cnt >= conv_term - 32'd1) &&
                     (ext_clk_sel ? ext_edge : 1'b1);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      conv_cnt <= '0;
    end else if (clk_en) begin
      if (state != ADCSQ_CONV || conv_done) begin
        conv_cnt <= '0;
      end else if (!ext_clk_sel || ext_edge) begin
        // A source switch keeps counting; only this result may be off
        conv_cnt <= conv_cnt + 32'd1;
      end
    end
  end

  // Sequencer
  always_comb begin
    next_state = state;
    unique case (state)
      ADCSQ_POR:   next_state = ADCSQ_CONV;
      ADCSQ_CONV:  if (conv_done) next_state = ADCSQ_SLEEP;
      ADCSQ_SLEEP: if (!cs_n) next_state = ADCSQ_DOUT;
      ADCSQ_DOUT:  if (cs_n || bit_cnt == WORD_LAST) next_state = ADCSQ_CONV;
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ADCSQ_POR;
    end else if (clk_en) begin
      state <= por_active ? ADCSQ_POR : next_state;
    end
  end

  // Sign of a zero code flips each 2x conversion
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      zero_sign <= 1'b1;
    end else if (clk_en && por_active) begin
      zero_sign <= 1'b1;
    end else if (clk_en && conv_done && rate_2x) begin
      zero_sign <= ~zero_sign;
    end
  end

  // Compose the word from this result; a 2x zero takes its sign from zero_sign
  always_comb begin
    word                    = '0;
    word[BIT_EOC]           = 1'b0;
    word[BIT_ZERO]          = 1'b0; // zero_filler_bit
    word[BIT_SIGN]          = mod_result.sign;
    word[BIT_MSB:BIT_LSB]   = mod_result.value;
    word[BIT_LSB-1:0]       = mod_result.sub_lsb;
    if (mod_result.over) begin
      word[BIT_SIGN:0] = {2'b11, 28'h0000000};
    end else if (mod_result.under) begin
      word[BIT_SIGN:0] = {2'b00, 28'hFFFFFFF};
    end else if (mod_result.value == 24'h000000 && mod_result.sub_lsb == 5'h00 && rate_2x) begin
      word[BIT_SIGN] = zero_sign;
    end
  end

  // Capture at end of conversion; shift on serial clock falls
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      shift_word <= 32'h80000000;
      bit_cnt    <= '0;
    end else if (clk_en) begin
      if (conv_done) begin
        shift_word <= word;
        bit_cnt    <= '0;
      end else if (state == ADCSQ_DOUT && sck_fall && bit_cnt < WORD_LAST) begin
        // Bits advance on strobes only, so clock jitter never corrupts data
        shift_word <= {shift_word[30:0], 1'b1};
        bit_cnt    <= bit_cnt + 6'd1;
      end else if (state == ADCSQ_CONV || state == ADCSQ_POR) begin
        // Internal reset also clears a word left over from sleep
        shift_word <= 32'h80000000;
        bit_cnt    <= '0;
      end
    end
  end

  // Outputs
  assign conv_busy = (state == ADCSQ_CONV) || (state == ADCSQ_POR);
  assign sdo_oe    = ~cs_n;
  assign sdo_bit   = shift_word[BIT_EOC];
  assign word_done = (state == ADCSQ_DOUT) && (bit_cnt == WORD_LAST);

  // Checks
  property p_por_hold;
    @(posedge mclk) disable iff (!reset_n) clk_en && !supply_ok |=> por_active;
  endproperty
  a_por_hold: assert property (p_por_hold) else $error("reset not held at low supply");

  property p_cfg_default;
    @(posedge mclk) disable iff (!reset_n) clk_en && por_active |=> reject_mode == REJ_CMB;
  endproperty
  a_cfg_default: assert property (p_cfg_default) else $error("default mode lost");

  property p_por_to_conv;
    @(posedge mclk) disable iff (!reset_n)
      clk_en && $fell(por_active) |=> state == ADCSQ_CONV;
  endproperty
  a_por_to_conv: assert property (p_por_to_conv) else $error("no conversion after reset");

  property p_sleep_hold;
    @(posedge mclk) disable iff (!reset_n)
      clk_en && state == ADCSQ_SLEEP && cs_n && !por_active |=> state == ADCSQ_SLEEP;
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("left sleep with select high");

  property p_osc_off;
    @(posedge mclk) disable iff (!reset_n)
      clk_en && !por_active && ext_edge |=> ext_clk_sel && !osc_enable;
  endproperty
  a_osc_off: assert property (p_osc_off) else $error("oscillator on with external clock");

  sequence s_done_seen;
    clk_en && conv_done && !por_active;
  endsequence
  property p_done_sleep;
    @(posedge mclk) disable iff (!reset_n) s_done_seen |=> state == ADCSQ_SLEEP && !sdo_bit;
  endproperty
  a_done_sleep: assert property (p_done_sleep) else $error("conversion end not shown");

  property p_cap32;
    @(posedge mclk) disable iff (!reset_n) bit_cnt <= WORD_LAST;
  endproperty
  a_cap32: assert property (p_cap32) else $error("more than 32 bits shifted");

  property p_no_rsvd;
    @(posedge mclk) disable iff (!reset_n) reject_mode != REJ_RSVD;
  endproperty
  a_no_rsvd: assert property (p_no_rsvd) else $error("reserved rejection code applied");

  property p_temp_1x;
    @(posedge mclk) disable iff (!reset_n) temp_sel |-> !rate_2x && cal_offset_en;
  endproperty
  a_temp_1x: assert property (p_temp_1x) else $error("temperature input at 2x");

  // Frame ends by abort or after the last bit, then a new conversion
  sequence s_frame_end;
    clk_en && !por_active && state == ADCSQ_DOUT && (cs_n || word_done);
  endsequence
  property p_frame_end;
    @(posedge mclk) disable iff (!reset_n) s_frame_end |=> state == ADCSQ_CONV;
  endproperty
  a_frame_end: assert property (p_frame_end) else $error("frame end not followed by conversion");

  property p_over_code;
    @(posedge mclk) disable iff (!reset_n)
      clk_en && conv_done && mod_result.over |=>
        shift_word[BIT_SIGN:BIT_MSB] == 2'b11 && shift_word[BIT_MSB-1:0] == '0;
  endproperty
  a_over_code: assert property (p_over_code) else $error("over range code wrong");

endmodule // adcsq_top

/* include/adcsq_pkg.sv */
// Purpose: Shared constants and types for the conversion sequencer
// Assumes: mclk at 100 MHz
// Notes:   Times are kept in their printed unit; cycle counts are derived
package adcsq_pkg;

  localparam int CLK_PERIOD_NS = 10;

  // Printed times in microseconds
  localparam int T_POR_US       = 4000;
  localparam int T_CONV_60_1X   = 133000;
  localparam int T_CONV_50_1X   = 160000;
  localparam int T_CONV_CMB_1X  = 147000;
  localparam int T_CONV_60_2X   = 67000;
  localparam int T_CONV_50_2X   = 80000;
  localparam int T_CONV_CMB_2X  = 73600;
  localparam int T_DOUT_INT_US  = 830;

  // Least times round up, longest times round down
  localparam int POR_CYC      = (T_POR_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int C60_1X_CYC   = (T_CONV_60_1X * 1000) / CLK_PERIOD_NS;
  localparam int C50_1X_CYC   = (T_CONV_50_1X * 1000) / CLK_PERIOD_NS;
  localparam int CCMB_1X_CYC  = (T_CONV_CMB_1X * 1000) / CLK_PERIOD_NS;
  localparam int C60_2X_CYC   = (T_CONV_60_2X * 1000) / CLK_PERIOD_NS;
  localparam int C50_2X_CYC   = (T_CONV_50_2X * 1000) / CLK_PERIOD_NS;
  localparam int CCMB_2X_CYC  = (T_CONV_CMB_2X * 1000) / CLK_PERIOD_NS;
  localparam int DOUT_INT_CYC = (T_DOUT_INT_US * 1000) / CLK_PERIOD_NS;

  // External clock figures
  localparam logic [23:0] EXT_CONV_1X   = 24'd41036;
  localparam logic [23:0] EXT_CONV_2X   = 24'd20556;
  localparam int          EXT_DOUT_PER  = 256;
  localparam int          FILTER_DIV    = 5120;
  localparam int          EXT_MIN_HZ    = 10000;
  // Longest gap between external edges before falling back
  localparam int          EXT_LOSS_CYC  = 1000000000 / (EXT_MIN_HZ * CLK_PERIOD_NS);

  localparam int          WORD_BITS     = 32;
  localparam logic [5:0]  WORD_LAST     = 6'd32;

  // Rejection select encodings
  localparam logic [1:0] REJ_CMB  = 2'b00;
  localparam logic [1:0] REJ_50   = 2'b01;
  localparam logic [1:0] REJ_60   = 2'b10;
  localparam logic [1:0] REJ_RSVD = 2'b11;

  // Output word field positions
  localparam int BIT_EOC  = 31;
  localparam int BIT_ZERO = 30;
  localparam int BIT_SIGN = 29;
  localparam int BIT_MSB  = 28;
  localparam int BIT_LSB  = 5;

  typedef enum logic [1:0] {
    ADCSQ_POR  = 2'b00,
    ADCSQ_CONV = 2'b01,
    ADCSQ_SLEEP = 2'b10,
    ADCSQ_DOUT = 2'b11
  } adcsq_state_e;

  typedef struct packed {
    logic       enable;
    logic       temp_input_select;
    logic       reject_sel_a;
    logic       reject_sel_b;
    logic       double_rate_select;
  } adcsq_cfg_s;

  typedef struct packed {
    logic        sign;
    logic [23:0] value;
    logic [4:0]  sub_lsb;
    logic        over;
    logic        under;
  } adcsq_result_s;

endpackage
